// ===== src/tcp_regs.svh
`ifndef TCP_REGS_SVH
`define TCP_REGS_SVH

// Register indices; byte address is four times the index
`define TCP_IDX_SELECT    7'h00
`define TCP_IDX_COUNTER   7'h04
`define TCP_IDX_CTRL1     7'h06
`define TCP_IDX_EDGE      7'h0A
`define TCP_IDX_CIE       7'h0C
`define TCP_IDX_CTRL2     7'h0D
`define TCP_IDX_FLG1      7'h0E
`define TCP_IDX_FLG2      7'h0F
`define TCP_IDX_ACC       7'h20
// Channel value registers sit at base + 2 * channel
`define TCP_CHAN_HI       3'h1

// Field positions
`define TCP_BIT_TEN       7
`define TCP_BIT_FAST      4
`define TCP_BIT_TOI       7
`define TCP_BIT_COUNTER_RESET_ENABLE      3
`define TCP_PR_MSB        2
`define TCP_BIT_OVF       7
`define TCP_BIT_ACCUMULATOR_ENABLE_BIT      6
`define TCP_CH_MOD        7

// Values
`define TCP_CNT_ZERO      16'h0000
`define TCP_CNT_MAX       16'hFFFF
`define TCP_VAL_RST       16'h0000
`define TCP_REG8_RST      8'h00
`define TCP_REG16_RST     16'h0000
`define TCP_PR_RST        3'h0
`define TCP_RESP_OKAY     2'b00
`define TCP_RESP_SLVERR   2'b10

`endif

// ===== src/tcp_pkg.sv
package tcp_pkg;
  // Capture edge selection, in field encoding order
  typedef enum logic [1:0] {edge_off, edge_rise, edge_fall, edge_both} tcp_edge_t;
  typedef logic [15:0] tcp_count_t;
endpackage

// ===== src/tcp_prescaler.sv
`timescale 1ns/1ps
`include "tcp_regs.svh"
module tcp_prescaler
  import tcp_pkg::*;
#(
  parameter int STAGES = 7
)(
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // Control
  input  wire logic              run_i,
  input  wire logic              restart_i,
  input  wire logic [2:0]        sel_i,
  // Tick out
  output logic                   tick_o
);
  if (STAGES != 7) $error("prescaler needs seven stages for codes 0..7");

  logic [STAGES-1:0] ps_q;
  logic [2:0]        sel_act_q;
  logic [STAGES-1:0] mask;

  // Divisor is two to the active select
  assign mask   = STAGES'((8'h01 << sel_act_q) - 8'h01);
  assign tick_o = run_i && ((ps_q & mask) == mask);

  // Stage counter, restarted on a modulus reset
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      ps_q <= '0;
    else if (restart_i || !run_i)
      ps_q <= '0;
    else
      ps_q <= ps_q + STAGES'(1);

  // New factor only at a point where all stages are zero
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      sel_act_q <= `TCP_PR_RST;
    else if (ps_q == '0)
      sel_act_q <= sel_i;

  property p_sel_sync;
    @(posedge sys_clk_i) disable iff (rst_i)
    $changed(sel_act_q) |-> $past(ps_q) == '0;
  endproperty
  a_sel_sync: assert property (p_sel_sync) else $error("prescale changed off sync point");

  property p_div128;
    @(posedge sys_clk_i) disable iff (rst_i)
    (tick_o && sel_act_q == 3'h7 && run_i && !restart_i) |=> !tick_o;
  endproperty
  a_div128: assert property (p_div128) else $error("divide by 128 ticked twice");
endmodule

// ===== src/tcp_edge_detect.sv
`timescale 1ns/1ps
module tcp_edge_detect
  import tcp_pkg::*;
#(
  parameter int CH = 8
)(
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // Pins and configuration
  input  wire logic [CH-1:0]     pin_i,
  input  wire logic [2*CH-1:0]   edge_sel_i,
  // Per channel edge events
  output logic [CH-1:0]          edge_o
);
  if (CH < 1) $error("edge detector needs at least one channel");

  logic [CH-1:0] prev_q;

  function automatic logic edge_hit(input tcp_edge_t mode, input logic rise, input logic fall);
    edge_hit = ((mode == edge_rise) && rise) || ((mode == edge_fall) && fall)
            || ((mode == edge_both) && (rise || fall));
  endfunction

  // Pins are synchronous already; one stage of history suffices
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      prev_q <= '0;
    else
      prev_q <= pin_i;

  // Decode each channel's two-bit edge control
  always_comb
  begin
    for (int i = 0; i < CH; i++)
      edge_o[i] = edge_hit(tcp_edge_t'(edge_sel_i[2*i +: 2]),
                           pin_i[i] && !prev_q[i], !pin_i[i] && prev_q[i]);
  end
endmodule

// ===== src/tcp_timer_core.sv
// Overview of operation
// - Overflow flag and enable raise overflow request
// - Counter reset enable: channel 7 compare restarts counter
// - Reset enabled, channel 7 zero: counter holds zero
// - Reset enabled, channel 7 max: no overflow flag
// - Modulus period is compare times divisor plus one
// - Prescale field divides bus clock by powers two
// - New prescale applies when all stages zero
// - Capture or compare event sets channel flag
// - Write one clears flag when timer/accumulator enabled
// - Writing zero leaves channel flag unchanged
// - Fast clear: capture read, compare write clear flag
// - Fast clear: counter access clears overflow flag
// - Counter wrap from max to zero sets overflow
// - Write one bit 7 clears overflow when enabled
// - Capture edge latches counter into value register
// - Value writes ignored in capture, accepted compare
// - Value registers reset to zero
// - Channel flag requests interrupt only when enabled
// - Two-bit edge control selects capture edges
`timescale 1ns/1ps
`include "tcp_regs.svh"
module tcp_timer_core
  import tcp_pkg::*;
#(
  parameter int CH     = 8,
  parameter int ADDR_W = 9
)(
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // AXI4-Lite write address and data
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  // Capture pins
  input  wire logic [CH-1:0]     capture_pin_i,
  // Requests and events
  output logic                   overflow_irq_o,
  output logic [CH-1:0]          channel_irq_o,
  output logic [CH-1:0]          compare_event_o
);
  if (CH != 8) $error("timer core serves exactly eight channels");
  if (ADDR_W < 9) $error("address must reach index 0x20");

  // Software visible state
  logic [7:0]   select_q, cie_q, flg1_q;
  logic [15:0]  edge_q;
  logic         ten_q, fast_q, accumulator_enable_bit_q, toi_q, counter_reset_enable_q, ovf_q;
  logic [2:0]   pr_q;
  tcp_count_t   cnt_q;
  tcp_count_t   val_q [CH];
  logic         cnt_new_q;
  // Bus slave state
  logic              aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0]       wdata_q, rdata_q, rd_data;
  logic [3:0]        wstrb_q;
  logic [1:0]        bresp_q, rresp_q;
  logic              rd_ok;
  // Internal events
  logic              wr_fire, rd_fire, tick, mod_reset, ovf_set, ovf_clr, clr_en;
  logic [6:0]        w_idx, r_idx;
  logic [CH-1:0]     edge_evt, cmp_hit, flg_set, flg_clr;

  function automatic logic is_chan(input logic [6:0] idx);
    is_chan = (idx[6:4] == `TCP_CHAN_HI) && !idx[0];
  endfunction

  function automatic logic [2:0] chan_of(input logic [6:0] idx);
    chan_of = idx[3:1];
  endfunction

  function automatic logic is_mapped(input logic [6:0] idx);
    is_mapped = is_chan(idx) || idx == `TCP_IDX_SELECT || idx == `TCP_IDX_COUNTER
             || idx == `TCP_IDX_CTRL1 || idx == `TCP_IDX_EDGE || idx == `TCP_IDX_CIE
             || idx == `TCP_IDX_CTRL2 || idx == `TCP_IDX_FLG1 || idx == `TCP_IDX_FLG2
             || idx == `TCP_IDX_ACC;
  endfunction

  // Byte lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  assign w_idx   = awaddr_q[8:2];
  assign r_idx   = s_axi_araddr_i[8:2];
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
  assign clr_en  = ten_q || accumulator_enable_bit_q;

  // Handshakes; address and data are taken in either order
  assign s_axi_awready_o = !aw_have_q && !bvalid_q;
  assign s_axi_wready_o  = !w_have_q && !bvalid_q;
  assign s_axi_arready_o = !rvalid_q;
  assign s_axi_bvalid_o  = bvalid_q;
  assign s_axi_bresp_o   = bresp_q;
  assign s_axi_rvalid_o  = rvalid_q;
  assign s_axi_rdata_o   = rdata_q;
  assign s_axi_rresp_o   = rresp_q;

  // Write channel capture and response
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `TCP_RESP_OKAY;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wstrb_q   <= '0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata_i;
        wstrb_q  <= s_axi_wstrb_i;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
        bvalid_q  <= 1'b1;
        bresp_q   <= is_mapped(w_idx) ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready_i)
        bvalid_q <= 1'b0;
    end

  // Read mux; unmapped reads return zero with an error
  always_comb
  begin
    rd_data = '0;
    rd_ok   = 1'b1;
    if (is_chan(r_idx))
      rd_data = {16'h0000, val_q[chan_of(r_idx)]};
    else
      case (r_idx)
        `TCP_IDX_SELECT:  rd_data[7:0] = select_q;
        `TCP_IDX_COUNTER: rd_data[15:0] = cnt_q;
        `TCP_IDX_CTRL1:   rd_data[7:0] = {ten_q, 2'b00, fast_q, 4'h0};
        `TCP_IDX_EDGE:    rd_data[15:0] = edge_q;
        `TCP_IDX_CIE:     rd_data[7:0] = cie_q;
        `TCP_IDX_CTRL2:   rd_data[7:0] = {toi_q, 3'b000, counter_reset_enable_q, pr_q};
        `TCP_IDX_FLG1:    rd_data[7:0] = flg1_q;
        `TCP_IDX_FLG2:    rd_data[7:0] = {ovf_q, 7'h00};
        `TCP_IDX_ACC:     rd_data[7:0] = {1'b0, accumulator_enable_bit_q, 6'h00};
        default:          rd_ok = 1'b0;
      endcase
  end

  // Read response register
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= `TCP_RESP_OKAY;
    end
    else if (rd_fire)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_data;
      rresp_q  <= rd_ok ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready_i)
      rvalid_q <= 1'b0;

  // Control registers written from the low byte lane; the edge register takes both low lanes
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      select_q <= `TCP_REG8_RST;
      cie_q    <= `TCP_REG8_RST;
      edge_q   <= `TCP_REG16_RST;
      ten_q    <= 1'b0;
      fast_q   <= 1'b0;
      accumulator_enable_bit_q   <= 1'b0;
      toi_q    <= 1'b0;
      counter_reset_enable_q   <= 1'b0;
      pr_q     <= `TCP_PR_RST;
    end
    else if (wr_fire)
    begin
      if (w_idx == `TCP_IDX_EDGE)
        edge_q <= merge16(edge_q, wdata_q, wstrb_q);
      if (wstrb_q[0])
        case (w_idx)
          `TCP_IDX_SELECT: select_q <= wdata_q[7:0];
          `TCP_IDX_CIE:    cie_q <= wdata_q[7:0];
          `TCP_IDX_CTRL1:
          begin
            ten_q  <= wdata_q[`TCP_BIT_TEN];
            fast_q <= wdata_q[`TCP_BIT_FAST];
          end
          `TCP_IDX_CTRL2:
          begin
            toi_q  <= wdata_q[`TCP_BIT_TOI];
            counter_reset_enable_q <= wdata_q[`TCP_BIT_COUNTER_RESET_ENABLE];
            pr_q   <= wdata_q[`TCP_PR_MSB:0];
          end
          `TCP_IDX_ACC:    accumulator_enable_bit_q <= wdata_q[`TCP_BIT_ACCUMULATOR_ENABLE_BIT];
          default:         ;
        endcase
    end

  // Prescaler restarts with the counter so a modulus period is exact
  tcp_prescaler #(.STAGES(7)) u_prescaler (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .run_i     (ten_q),
    .restart_i (mod_reset),
    .sel_i     (pr_q),
    .tick_o    (tick)
  );

  tcp_edge_detect #(.CH(CH)) u_edge (
    .sys_clk_i  (sys_clk_i),
    .rst_i      (rst_i),
    .pin_i      (capture_pin_i),
    .edge_sel_i (edge_q),
    .edge_o     (edge_evt)
  );

  // Compare fires once per fresh counter value, not while it idles
  always_comb
  begin
    for (int i = 0; i < CH; i++)
      cmp_hit[i] = ten_q && cnt_new_q && select_q[i] && (cnt_q == val_q[i]);
  end

  // A stale match at a tick restarts too, so a counter parked on the
  // compare value (zero included) cannot slip past it into a full wrap
  assign mod_reset = counter_reset_enable_q && (cmp_hit[`TCP_CH_MOD]
                     || (select_q[`TCP_CH_MOD] && tick
                         && cnt_q == val_q[`TCP_CH_MOD]));
  // A modulus reset bypasses the increment, so a max compare never wraps
  assign ovf_set   = tick && !mod_reset && (cnt_q == `TCP_CNT_MAX);

  // Free-running counter; reset wins over the tick
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      cnt_q     <= `TCP_CNT_ZERO;
      cnt_new_q <= 1'b0;
    end
    else
    begin
      cnt_new_q <= mod_reset || tick;
      if (mod_reset)
        cnt_q <= `TCP_CNT_ZERO;
      else if (tick)
        cnt_q <= cnt_q + 16'h0001;
    end

  // Flag set and clear terms; set wins over clear
  always_comb
  begin
    for (int i = 0; i < CH; i++)
    begin
      flg_set[i] = (select_q[i] ? cmp_hit[i] : (ten_q && edge_evt[i]));
      flg_clr[i] = (wr_fire && w_idx == `TCP_IDX_FLG1 && wstrb_q[0] && clr_en
                    && wdata_q[i])
                || (fast_q && rd_fire && is_chan(r_idx) && chan_of(r_idx) == 3'(i)
                    && !select_q[i])
                || (fast_q && wr_fire && is_chan(w_idx) && chan_of(w_idx) == 3'(i)
                    && select_q[i]);
    end
  end

  assign ovf_clr = (wr_fire && w_idx == `TCP_IDX_FLG2 && wstrb_q[0] && clr_en
                    && wdata_q[`TCP_BIT_OVF])
                || (fast_q && ((rd_fire && r_idx == `TCP_IDX_COUNTER)
                    || (wr_fire && w_idx == `TCP_IDX_COUNTER)));

  // Channel flags
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      flg1_q <= `TCP_REG8_RST;
    else
      flg1_q <= (flg1_q & ~flg_clr) | flg_set;

  // Overflow flag
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      ovf_q <= 1'b0;
    else if (ovf_set)
      ovf_q <= 1'b1;
    else if (ovf_clr)
      ovf_q <= 1'b0;

  // Value registers: capture latches, compare mode takes writes
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      for (int i = 0; i < CH; i++)
        val_q[i] <= `TCP_VAL_RST;
    end
    else
    begin
      for (int i = 0; i < CH; i++)
        if (!select_q[i] && ten_q && edge_evt[i])
          val_q[i] <= cnt_q;
        else if (select_q[i] && wr_fire && is_chan(w_idx) && chan_of(w_idx) == 3'(i))
          val_q[i] <= merge16(val_q[i], wdata_q, wstrb_q);
    end

  // Compare events registered for output
  always_ff @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      compare_event_o <= '0;
    else
      compare_event_o <= cmp_hit;

  // Requests are levels straight from flags and enables
  assign overflow_irq_o = ovf_q && toi_q;
  assign channel_irq_o  = flg1_q & cie_q;

  property p_ovf_irq;
    @(posedge sys_clk_i) disable iff (rst_i)
    ovf_set && toi_q |=> overflow_irq_o;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow request missing");

  property p_mod_reset;
    @(posedge sys_clk_i) disable iff (rst_i)
    counter_reset_enable_q && cmp_hit[7] |=> cnt_q == 16'h0000 ##1 (cnt_q == 16'h0000 || !ten_q || tick);
  endproperty
  a_mod_reset: assert property (p_mod_reset) else $error("modulus reset missed");

  property p_hold_zero;
    @(posedge sys_clk_i) disable iff (rst_i)
    (counter_reset_enable_q && ten_q && select_q[7] && val_q[7] == 16'h0000 && cnt_q == 16'h0000 && cnt_new_q)
      |=> cnt_q == 16'h0000;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("counter left zero");

  property p_no_ovf_max;
    @(posedge sys_clk_i) disable iff (rst_i)
    (counter_reset_enable_q && ten_q && select_q[7] && val_q[7] == 16'hFFFF && cnt_q == 16'hFFFF)
      |-> !ovf_set;
  endproperty
  a_no_ovf_max: assert property (p_no_ovf_max) else $error("overflow set at max compare");

  property p_increment;
    @(posedge sys_clk_i) disable iff (rst_i)
    tick && !mod_reset |=> cnt_q == 16'($past(cnt_q) + 16'h0001);
  endproperty
  a_increment: assert property (p_increment) else $error("counter did not step");

  property p_flag_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    |flg_set |=> (flg1_q & $past(flg_set)) == $past(flg_set);
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("channel flag not set");

  property p_w1c;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_fire && w_idx == `TCP_IDX_FLG1 && wstrb_q[0] && clr_en && flg_set == 8'h00)
      |=> (flg1_q & $past(wdata_q[7:0])) == 8'h00;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_w0_keep;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr_fire && w_idx == `TCP_IDX_FLG1 && !fast_q)
      |=> ($past(flg1_q) & ~$past(wdata_q[7:0]) & ~flg1_q) == 8'h00;
  endproperty
  a_w0_keep: assert property (p_w0_keep) else $error("write zero changed a flag");

  property p_fast_ovf;
    @(posedge sys_clk_i) disable iff (rst_i)
    (fast_q && rd_fire && r_idx == `TCP_IDX_COUNTER && !ovf_set) |=> !ovf_q;
  endproperty
  a_fast_ovf: assert property (p_fast_ovf) else $error("counter read kept overflow");

  property p_capture;
    @(posedge sys_clk_i) disable iff (rst_i)
    (!select_q[0] && ten_q && edge_evt[0]) |=> val_q[0] == $past(cnt_q);
  endproperty
  a_capture: assert property (p_capture) else $error("capture not latched");

  property p_bhold;
    @(posedge sys_clk_i) disable iff (rst_i)
    bvalid_q && !s_axi_bready_i |=> bvalid_q;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");

  c_mod_reset: cover property (@(posedge sys_clk_i) disable iff (rst_i) mod_reset);
  c_overflow: cover property (@(posedge sys_clk_i) disable iff (rst_i) ovf_set);
  c_capture: cover property (@(posedge sys_clk_i) disable iff (rst_i) |(edge_evt & ~select_q));
  c_fast_clr: cover property (@(posedge sys_clk_i) disable iff (rst_i) fast_q && |flg_clr);
endmodule

// ===== tb/tcp_timer_core_bench.sv
`timescale 1ns/1ps
`include "tcp_regs.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin failures++; $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module tcp_timer_core_bench
  import tcp_pkg::*;
;
  // Clock, reset and bus master signals
  logic        sys_clk_i;
  logic        rst_i;
  logic [8:0]  aw_addr;
  logic        aw_valid;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_valid;
  logic        b_ready;
  logic [8:0]  ar_addr;
  logic        ar_valid;
  logic        r_ready;
  logic [7:0]  capture_pin;
  // Design outputs
  logic        awready, wready, bvalid, arready, rvalid, ovf_irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [7:0]  ch_irq, cmp_ev;
  // Bench model state
  int          failures = 0;
  int          n_compared = 0;
  int          seed = 63521;
  int          gap = 0;
  int          last_gap = 0;
  int          n_ev = 0;
  int          i, m, p, v, k, cap;
  logic [31:0] rd_val;
  logic [1:0]  last_resp;

  tcp_timer_core #(.CH(8), .ADDR_W(9)) uut (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(aw_addr), .s_axi_awvalid_i(aw_valid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(w_data), .s_axi_wstrb_i(w_strb), .s_axi_wvalid_i(w_valid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(b_ready), .s_axi_araddr_i(ar_addr), .s_axi_arvalid_i(ar_valid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(r_ready), .capture_pin_i(capture_pin),
    .overflow_irq_o(ovf_irq), .channel_irq_o(ch_irq), .compare_event_o(cmp_ev)
  );

  // 50 MHz bus clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // Spacing of channel 7 compare pulses, the modulus period
  always @(posedge sys_clk_i)
  begin
    gap = gap + 1;
    if (cmp_ev[7] === 1'b1)
    begin
      last_gap = gap;
      n_ev = n_ev + 1;
      gap = 0;
    end
  end

  task give_verdict;
    if (failures == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Full-word write, both lanes together so high and low byte land at once
  task wr(input int idx, input int d);
    @(posedge sys_clk_i);
    aw_addr <= 9'(idx * 4);
    aw_valid <= 1'b1;
    w_data <= 32'(d);
    w_strb <= 4'hF;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    forever
    begin
      @(posedge sys_clk_i);
      if (aw_valid && awready)
        aw_valid <= 1'b0;
      if (w_valid && wready)
        w_valid <= 1'b0;
      if (bvalid)
      begin
        last_resp = bresp;
        b_ready <= 1'b0;
        break;
      end
    end
  endtask

  // Single read; holds rready until the answer is sampled
  task rd(input int idx);
    @(posedge sys_clk_i);
    ar_addr <= 9'(idx * 4);
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    forever
    begin
      @(posedge sys_clk_i);
      if (ar_valid && arready)
        ar_valid <= 1'b0;
      if (rvalid)
      begin
        rd_val = rdata;
        last_resp = rresp;
        r_ready <= 1'b0;
        break;
      end
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  // Hang guard, sized for one full 16-bit wrap plus the shorter tests
  initial
  begin
    repeat (95000) @(posedge sys_clk_i);
    failures++;
    give_verdict();
  end

  // Main sequence
  initial
  begin
    rst_i = 1'b1;
    {aw_addr, aw_valid, w_data, w_strb, w_valid, b_ready} = '0;
    {ar_addr, ar_valid, r_ready, capture_pin} = '0;
    cyc(3);
    rst_i <= 1'b0;
    // Reset contents of value and flag registers
    for (i = 0; i < 8; i++)
    begin
      rd(16 + 2 * i);
      `CHK(rd_val, 32'h0000_0000)
    end
    rd(`TCP_IDX_FLG1);
    `CHK(rd_val, 32'h0000_0000)
    rd(`TCP_IDX_FLG2);
    `CHK(rd_val, 32'h0000_0000)
    // Unmapped place is refused both ways
    wr(7'h7F, 32'h5A);
    `CHK(last_resp, `TCP_RESP_SLVERR)
    rd(7'h7F);
    `CHK({last_resp, rd_val}, {`TCP_RESP_SLVERR, 32'h0})
    // Modulus period for every prescale code, random compare value
    // Modulus armed before the count starts, so the counter parks at zero;
    // compare values only grow, so the counter never wraps to reach one
    wr(`TCP_IDX_SELECT, 32'h81);
    wr(`TCP_IDX_CTRL2, 32'h08);
    wr(`TCP_IDX_CTRL1, 32'h80);
    v = 0;
    for (p = 0; p < 8; p++)
    begin
      v = v + ($random(seed) & 1) + 1;
      wr(`TCP_IDX_CTRL2, 32'h08 | p);
      wr(16 + 14, v);
      k = n_ev;
      for (m = 0; m < 9000 && n_ev < k + 3; m++) @(posedge sys_clk_i);
      `CHK(last_gap, v * (1 << p) + 1)
    end
    // Channel 7 compare at zero pins the counter
    wr(16 + 14, 0);
    cyc(20);
    rd(`TCP_IDX_COUNTER);
    `CHK(rd_val[15:0], 16'h0000)
    cyc(50);
    rd(`TCP_IDX_COUNTER);
    `CHK(rd_val[15:0], 16'h0000)
    // Channel 0 compare flag, enable and clear gating; undivided clock
    // keeps the waits for a compare short
    wr(`TCP_IDX_CTRL2, 32'h08);
    wr(`TCP_IDX_CIE, 32'h01);
    wr(16, 20);
    wr(16 + 14, 40);
    for (m = 0; m < 200 && ch_irq[0] !== 1'b1; m++) @(posedge sys_clk_i);
    `CHK(ch_irq[0], 1'b1)
    rd(`TCP_IDX_FLG1);
    `CHK(rd_val[0], 1'b1)
    wr(`TCP_IDX_FLG1, 32'h00);
    rd(`TCP_IDX_FLG1);
    `CHK(rd_val[0], 1'b1)
    wr(`TCP_IDX_CTRL1, 32'h00);
    wr(`TCP_IDX_FLG1, 32'h01);
    rd(`TCP_IDX_FLG1);
    `CHK(rd_val[0], 1'b1)
    wr(`TCP_IDX_ACC, 32'h40);
    wr(`TCP_IDX_FLG1, 32'hFF);
    rd(`TCP_IDX_FLG1);
    `CHK(rd_val[7:0], 8'h00)
    `CHK(ch_irq, 8'h00)
    // Fast clear by writing a compare value out of reach
    wr(`TCP_IDX_ACC, 32'h00);
    wr(`TCP_IDX_CTRL1, 32'h90);
    for (m = 0; m < 200 && ch_irq[0] !== 1'b1; m++) @(posedge sys_clk_i);
    wr(16, 32'h8000);
    rd(`TCP_IDX_FLG1);
    `CHK(rd_val[0], 1'b0)
    rd(16);
    `CHK(rd_val[15:0], 16'h8000)
    // Channel 1 capture under each edge mode, slow counter
    wr(`TCP_IDX_CTRL2, 32'h07);
    for (m = 0; m < 4; m++)
    begin
      wr(`TCP_IDX_EDGE, m << 2);
      wr(`TCP_IDX_FLG1, 32'h02);
      rd(`TCP_IDX_COUNTER);
      k = rd_val[15:0];
      capture_pin <= 8'h02 | 8'($random(seed) & 8'h7C);
      cyc(4);
      rd(`TCP_IDX_FLG1);
      `CHK(rd_val[1], 1'(m & 1))
      if (m == 3)
      begin
        rd(16 + 2);
        cap = rd_val[15:0];
        `CHK(cap == k || cap == k + 1, 1'b1)
        rd(`TCP_IDX_FLG1);
        `CHK(rd_val[1], 1'b0)
        wr(16 + 2, 32'h1234);
        rd(16 + 2);
        `CHK(rd_val[15:0], 16'(cap))
      end
      wr(`TCP_IDX_FLG1, 32'h02);
      capture_pin <= 8'h00;
      cyc(4);
      rd(`TCP_IDX_FLG1);
      `CHK(rd_val[1], 1'(m >> 1))
    end
    // Free-running wrap sets overflow and its request
    wr(`TCP_IDX_CTRL2, 32'h80);
    for (m = 0; m < 70000 && ovf_irq !== 1'b1; m++) @(posedge sys_clk_i);
    `CHK(ovf_irq, 1'b1)
    rd(`TCP_IDX_FLG2);
    `CHK(rd_val[7:0], 8'h80)
    wr(`TCP_IDX_CTRL2, 32'h00);
    `CHK(ovf_irq, 1'b0)
    // Clear refused with both enables off, then counter access clears it
    wr(`TCP_IDX_CTRL1, 32'h00);
    wr(`TCP_IDX_FLG2, 32'h80);
    rd(`TCP_IDX_FLG2);
    `CHK(rd_val[7:0], 8'h80)
    wr(`TCP_IDX_CTRL1, 32'h10);
    rd(`TCP_IDX_COUNTER);
    rd(`TCP_IDX_FLG2);
    `CHK(rd_val[7:0], 8'h00)
    give_verdict();
  end
endmodule
